// File: shared/rf_stream_consts.svh
// Timing and field constants for the RF stream and transparent mode block.
`ifndef RF_STREAM_CONSTS_SVH
`define RF_STREAM_CONSTS_SVH
`define SC_DIV_BASE   10'h040
`define BPSK_DIV_BASE 10'h010
`define BPSK_DIV_MIN  10'h004
`define SC_PER_MIN    2'h1
`define QUIET_MAX     4'h8
`define TX_BIT_BASE   10'h080
`define BIT_IDX_LAST  3'h7
`define OP_ALL_OFF    4'h0
`endif

// File: shared/rf_stream_pkg.sv
// Types shared by the RF stream and transparent mode block.
package rf_stream_pkg;
    typedef struct packed {
        logic       bpsk;   // 1 selects BPSK stream reception.
        logic [1:0] scf;    // Sub-carrier frequency select.
        logic [1:0] scp;    // Sub-carrier periods per reporting period.
        logic [2:0] stx;    // Transmit bit period select.
    } stream_cfg_t;
    typedef struct packed {
        logic am_en;        // AM demodulation channel selected.
        logic pm_en;        // PM demodulation channel selected.
    } rx_chan_t;
    typedef enum logic [1:0] {
        RX_IDLE   = 2'b01,
        RX_ACTIVE = 2'b10
    } rx_state_t;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_LOAD = 3'b010,
        TX_BIT  = 3'b100
    } tx_state_t;
endpackage : rf_stream_pkg

// File: design/rf_stream_modes.sv
// Transparent mode pin control, stream receive and stream transmit logic.
//
// Operation
// - Manual trim select drives tuning switches directly
// - Slave select rising edge after command enters transparent
// - MOSI level drives transmit modulator
// - SCLK level drives receiver active signal
// - AM chain to MISO, PM chain to IRQ
// - Single channel goes to MISO, IRQ low
// - Transparent mode ignores stream and FIFO settings
// - Any serial command leaves transparent mode
// - Field detector drives IRQ in transparent mode
// - First bit goes to byte LSB
// - Sub-carrier mode: fc/64 to fc/8, 2-8 periods
// - Sub-carrier mode: start, then one bit per period
// - Sub-carrier end after over eight quiet periods
// - Sub-carrier selects: 01b is fc/32, 10b four
// - BPSK mode: fc/16 to fc/4, 1-8 periods
// - BPSK: start, 0 initial phase, 1 inverted
// - BPSK end at first quiet period
// - BPSK selects: 01b is fc/8, 01b two
// - Each transmit bit held, 1 modulates carrier
// - Transmit period select 000b is 128 carrier cycles
// - Stream transmission starts only on transmit command
`timescale 1ns/10ps
`include "rf_stream_consts.svh"

module rf_stream_modes
    import rf_stream_pkg::*;
#(
    parameter int CNT_W = 10
) (
    input  wire logic        clk,               // 250 MHz system clock.
    input  wire logic        sys_rst,           // Asynchronous reset, active high.
    input  wire logic        clk_en,            // Freezes all state while low.
    input  wire logic        fc_tick,           // One pulse per carrier cycle.
    input  wire logic        spi_ss_n,          // Serial slave select, active low.
    input  wire logic        mosi,              // Serial data in.
    input  wire logic        sclk,              // Serial clock pin level.
    input  wire logic        cmd_transparent,   // Transparent mode command pulse.
    input  wire logic        cmd_any,           // Pulse on any serial command.
    input  wire logic        cmd_transmit,      // Transmit command pulse.
    input  wire logic        spi_miso_data,     // Normal serial read data.
    input  wire logic        spi_miso_drive,    // Normal serial read drive request.
    input  wire logic        irq_normal,        // Normal interrupt request level.
    input  wire logic        am_sub,            // Digitized AM chain sub-carrier.
    input  wire logic        pm_sub,            // Digitized PM chain sub-carrier.
    input  wire rx_chan_t    rx_chan,           // Receive channel selection.
    input  wire logic        field_detect_enable, // External field detector enable.
    input  wire logic        ext_field,         // External field detector output.
    input  wire logic [3:0]  op_ctrl,           // Operation control bits.
    input  wire logic        trim_manual,       // Manual trim select.
    input  wire logic [3:0]  trim_value,        // Manual trim switch value.
    input  wire logic [3:0]  trim_auto,         // Calibration trim result.
    input  wire logic        stream_en,         // Stream protocol mode selected.
    input  wire stream_cfg_t cfg,               // Stream mode options.
    input  wire logic        rx_enable,         // Stream reception armed.
    input  wire logic        rx_on_normal,      // Receiver active outside transparent.
    input  wire logic        sc_detect,         // Sub-carrier present, carrier rate.
    input  wire logic        sc_phase,          // BPSK sub-carrier phase.
    input  wire logic        ook_sel,           // 1 selects OOK, 0 selects AM.
    input  wire logic [7:0]  tx_byte,           // Transmit FIFO byte.
    input  wire logic        tx_byte_valid,     // Transmit FIFO byte available.
    output logic             tx_byte_ready,     // Transmit FIFO byte taken.
    output logic             tx_done,           // Pulse when transmission ends.
    output logic             mod_on,            // Transmit modulator on.
    output logic             mod_ook,           // Modulation kind is OOK.
    output logic             rx_on,             // Receiver active, enables RSSI/AGC.
    output logic             miso_o,            // MISO pin output.
    output logic             miso_oe,           // MISO pin output enable.
    output logic             irq_o,             // IRQ pin output.
    output logic             transparent,       // Transparent mode active.
    output logic             low_power_target,  // Low-power target mode.
    output logic [3:0]       tuning_switch_pins, // Antenna trim switches.
    output logic             rx_start,          // Start of receive pulse.
    output logic             rx_end,            // End of receive pulse.
    output logic [7:0]       rx_byte,           // Received FIFO byte.
    output logic             rx_byte_valid      // Pulse with each received byte.
);

    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    if (CNT_W < 10) begin : g_chk
        $error("CNT_W must hold a 512 cycle reporting period");
    end

    // ----------------------------------------------------------------
    // Transparent mode control
    // ----------------------------------------------------------------
    logic ss_n_ff;
    logic armed_ff;
    logic trans_ff;
    wire  ss_rise = spi_ss_n && !ss_n_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ss_n_ff  <= 1'b1;
            armed_ff <= 1'b0;
            trans_ff <= 1'b0;
        end else if (clk_en) begin
            ss_n_ff <= spi_ss_n;
            // The arming command is itself a command, so arming wins.
            if (cmd_transparent) begin
                armed_ff <= 1'b1;
            end else if (cmd_any || ss_rise) begin
                armed_ff <= 1'b0;
            end
            if (ss_rise && armed_ff && !cmd_any) begin
                trans_ff <= 1'b1;
            end else if (cmd_any || !spi_ss_n) begin
                trans_ff <= 1'b0;
            end
        end
    end
    assign transparent = trans_ff;

    // ----------------------------------------------------------------
    // Pin outputs
    // ----------------------------------------------------------------
    logic mod_on_ff, mod_ook_ff, rx_on_ff, miso_ff, miso_oe_ff, irq_ff, lpt_ff;
    logic [3:0] trim_ff;
    logic       tx_mod;
    logic       nxt_miso, nxt_irq;

    always_comb begin
        nxt_miso = spi_miso_data;
        nxt_irq  = irq_normal;
        if (trans_ff) begin
            if (rx_chan.am_en && rx_chan.pm_en) begin
                nxt_miso = am_sub;
                nxt_irq  = pm_sub;
            end else begin
                nxt_miso = rx_chan.pm_en ? pm_sub : am_sub;
                nxt_irq  = 1'b0;
            end
            if (field_detect_enable) begin
                nxt_irq = ext_field;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mod_on_ff  <= 1'b0;
            mod_ook_ff <= 1'b0;
            rx_on_ff   <= 1'b0;
            miso_ff    <= 1'b0;
            miso_oe_ff <= 1'b0;
            irq_ff     <= 1'b0;
            lpt_ff     <= 1'b0;
            trim_ff    <= 4'h0;
        end else if (clk_en) begin
            mod_on_ff  <= trans_ff ? mosi : tx_mod;
            mod_ook_ff <= ook_sel;
            rx_on_ff   <= trans_ff ? sclk : rx_on_normal;
            miso_ff    <= nxt_miso;
            miso_oe_ff <= trans_ff || spi_miso_drive;
            irq_ff     <= nxt_irq;
            lpt_ff     <= field_detect_enable && (op_ctrl == `OP_ALL_OFF);
            trim_ff    <= trim_manual ? trim_value : trim_auto;
        end
    end
    assign mod_on             = mod_on_ff;
    assign mod_ook            = mod_ook_ff;
    assign rx_on              = rx_on_ff;
    assign miso_o             = miso_ff;
    assign miso_oe            = miso_oe_ff;
    assign irq_o              = irq_ff;
    assign low_power_target   = lpt_ff;
    assign tuning_switch_pins = trim_ff;

    // ----------------------------------------------------------------
    // Reporting period
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] div, rpt_len;
    logic [1:0]       per_sel;

    always_comb begin
        if (cfg.bpsk) begin
            div     = CNT_W'(`BPSK_DIV_BASE >> cfg.scf);
            per_sel = cfg.scp;
            if (div < CNT_W'(`BPSK_DIV_MIN)) begin
                div = CNT_W'(`BPSK_DIV_MIN);
            end
        end else begin
            div     = CNT_W'(`SC_DIV_BASE >> cfg.scf);
            per_sel = (cfg.scp < `SC_PER_MIN) ? `SC_PER_MIN : cfg.scp;
        end
        rpt_len = div << per_sel;
    end

    // ----------------------------------------------------------------
    // Stream reception
    // ----------------------------------------------------------------
    // Stream logic is held idle in transparent mode; the pins own the AFE then.
    wire rx_run = stream_en && rx_enable && !trans_ff;

    rx_state_t        rx_st_ff;
    logic [CNT_W-1:0] rcnt_ff;
    logic             seen_ff, phase_ff, ref_ff;
    logic [3:0]       quiet_ff;
    logic [7:0]       sh_ff;
    logic [2:0]       bcnt_ff;
    logic             start_ff, end_ff, bval_ff;
    logic [7:0]       byte_ff;

    wire rpt_end  = rx_run && fc_tick && (rcnt_ff == rpt_len - CNT_W'(1));
    wire seen_now = seen_ff || sc_detect;
    wire ph_now   = sc_detect ? sc_phase : phase_ff;

    logic put_bit, bit_val, finish;
    always_comb begin
        put_bit = 1'b0;
        bit_val = 1'b0;
        finish  = 1'b0;
        if (rpt_end) begin
            if (rx_st_ff == RX_IDLE) begin
                put_bit = seen_now;
                bit_val = !cfg.bpsk;
            end else if (cfg.bpsk) begin
                put_bit = seen_now;
                bit_val = ph_now ^ ref_ff;
                finish  = !seen_now;
            end else begin
                put_bit = 1'b1;
                bit_val = seen_now;
                finish  = !seen_now && (quiet_ff == `QUIET_MAX);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rcnt_ff  <= '0;
            seen_ff  <= 1'b0;
            phase_ff <= 1'b0;
        end else if (clk_en) begin
            if (!rx_run || rpt_end) begin
                rcnt_ff  <= '0;
                seen_ff  <= 1'b0;
            end else if (fc_tick) begin
                rcnt_ff  <= rcnt_ff + CNT_W'(1);
                seen_ff  <= seen_now;
                phase_ff <= ph_now;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_st_ff <= RX_IDLE;
            ref_ff   <= 1'b0;
            quiet_ff <= 4'h0;
            start_ff <= 1'b0;
            end_ff   <= 1'b0;
        end else if (clk_en) begin
            start_ff <= 1'b0;
            end_ff   <= 1'b0;
            if (!rx_run) begin
                rx_st_ff <= RX_IDLE;
            end else if (rpt_end) begin
                case (rx_st_ff)
                    RX_IDLE: begin
                        if (seen_now) begin
                            rx_st_ff <= RX_ACTIVE;
                            start_ff <= 1'b1;
                            ref_ff   <= ph_now;
                            quiet_ff <= 4'h0;
                        end
                    end
                    RX_ACTIVE: begin
                        quiet_ff <= seen_now ? 4'h0 : quiet_ff + 4'h1;
                        if (finish) begin
                            rx_st_ff <= RX_IDLE;
                            end_ff   <= 1'b1;
                        end
                    end
                    default: rx_st_ff <= RX_IDLE;
                endcase
            end
        end
    end

    // Bits shift in from the top so the first one ends at bit 0.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sh_ff   <= 8'h00;
            bcnt_ff <= 3'h0;
            byte_ff <= 8'h00;
            bval_ff <= 1'b0;
        end else if (clk_en) begin
            bval_ff <= 1'b0;
            if (put_bit) begin
                sh_ff   <= {bit_val, sh_ff[7:1]};
                bcnt_ff <= finish ? 3'h0 : bcnt_ff + 3'h1;
                if (bcnt_ff == `BIT_IDX_LAST) begin
                    byte_ff <= {bit_val, sh_ff[7:1]};
                    bval_ff <= 1'b1;
                end
            end else if (finish || !rx_run) begin
                // A partial last byte is dropped; only whole bytes reach the FIFO.
                bcnt_ff <= 3'h0;
            end
        end
    end
    assign rx_start      = start_ff;
    assign rx_end        = end_ff;
    assign rx_byte       = byte_ff;
    assign rx_byte_valid = bval_ff;

    // ----------------------------------------------------------------
    // Stream transmission
    // ----------------------------------------------------------------
    tx_state_t        tx_st_ff;
    logic [7:0]       tsh_ff;
    logic [2:0]       tbit_ff;
    logic [CNT_W-1:0] tcnt_ff;
    logic             done_ff;
    wire [CNT_W-1:0]  tx_len  = CNT_W'(`TX_BIT_BASE >> cfg.stx);
    wire              tx_tend = fc_tick && (tcnt_ff == tx_len - CNT_W'(1));

    assign tx_byte_ready = (tx_st_ff == TX_LOAD);
    assign tx_mod        = (tx_st_ff == TX_BIT) && tsh_ff[0];
    assign tx_done       = done_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_st_ff <= TX_IDLE;
            tsh_ff   <= 8'h00;
            tbit_ff  <= 3'h0;
            tcnt_ff  <= '0;
            done_ff  <= 1'b0;
        end else if (clk_en) begin
            done_ff <= 1'b0;
            case (tx_st_ff)
                TX_IDLE: begin
                    if (cmd_transmit && stream_en && !trans_ff) begin
                        tx_st_ff <= TX_LOAD;
                    end
                end
                TX_LOAD: begin
                    tcnt_ff <= '0;
                    tbit_ff <= 3'h0;
                    if (tx_byte_valid) begin
                        tsh_ff   <= tx_byte;
                        tx_st_ff <= TX_BIT;
                    end else begin
                        tx_st_ff <= TX_IDLE;
                        done_ff  <= 1'b1;
                    end
                end
                TX_BIT: begin
                    if (trans_ff) begin
                        tx_st_ff <= TX_IDLE;
                    end else if (tx_tend) begin
                        tcnt_ff <= '0;
                        tsh_ff  <= {1'b0, tsh_ff[7:1]};
                        tbit_ff <= tbit_ff + 3'h1;
                        if (tbit_ff == `BIT_IDX_LAST) begin
                            tx_st_ff <= TX_LOAD;
                        end
                    end else if (fc_tick) begin
                        tcnt_ff <= tcnt_ff + CNT_W'(1);
                    end
                end
                default: tx_st_ff <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_tx_cmd;
        clk_en && tx_st_ff == TX_IDLE && cmd_transmit && stream_en && !trans_ff;
    endsequence
    sequence s_tx_fetch;
        tx_st_ff == TX_LOAD && tx_byte_ready;
    endsequence

    a_trim_manual: assert property (clk_en && trim_manual |=> tuning_switch_pins == $past(trim_value))
        else $error("manual trim not applied");
    a_trans_entry: assert property (clk_en && ss_rise && armed_ff && !cmd_any |=> transparent)
        else $error("transparent mode not entered");
    a_trans_exit: assert property (clk_en && cmd_any && transparent |=> !transparent)
        else $error("command did not end transparent mode");
    a_mod_follow: assert property (clk_en && transparent |=> mod_on == $past(mosi))
        else $error("modulator does not follow MOSI");
    a_rx_on_pin: assert property (clk_en && transparent |=> rx_on == $past(sclk))
        else $error("receiver active does not follow SCLK");
    a_single_chan: assert property (clk_en && transparent && (rx_chan.am_en != rx_chan.pm_en)
                                    && !field_detect_enable |=> !irq_o)
        else $error("IRQ not low with one channel");
    a_fd_route: assert property (clk_en && transparent && field_detect_enable
                                 |=> irq_o == $past(ext_field))
        else $error("field detector not on IRQ");
    a_lp_target: assert property (clk_en && field_detect_enable && op_ctrl == `OP_ALL_OFF
                                  |=> low_power_target)
        else $error("low-power target mode missing");
    a_bpsk_end: assert property (clk_en && cfg.bpsk && rx_st_ff == RX_ACTIVE && rpt_end
                                 && !seen_now |=> rx_end && !rx_start)
        else $error("BPSK end of receive missing");
    a_tx_start: assert property (s_tx_cmd |=> s_tx_fetch)
        else $error("transmit command did not start fetch");
    a_tx_nocmd: assert property (tx_st_ff == TX_IDLE && !cmd_transmit |=> tx_st_ff == TX_IDLE)
        else $error("transmission began without command");

endmodule : rf_stream_modes

// File: bench/rf_fifo_model.sv
// Controller-side model of the transmit FIFO head that feeds stream transmission.
`timescale 1ns/10ps

module rf_fifo_model (
    input  wire logic       clk,           // System clock.
    input  wire logic       sys_rst,       // Asynchronous reset, active high.
    input  wire logic       push,          // Load one byte this cycle.
    input  wire logic [7:0] push_byte,     // Byte to load.
    input  wire logic       tx_byte_ready, // Block takes the head byte.
    output logic      [7:0] tx_byte,       // FIFO head.
    output logic            tx_byte_valid  // FIFO not empty.
);
    logic [7:0] mem_ff [16];
    logic [4:0] wr_ff;
    logic [4:0] rd_ff;

    // Pointers move on non-blocking updates so the block samples a stable head.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ff <= 5'h00;
            rd_ff <= 5'h00;
        end else begin
            if (push) begin
                mem_ff[wr_ff[3:0]] <= push_byte;
                wr_ff              <= wr_ff + 5'h01;
            end
            if (tx_byte_ready && tx_byte_valid) begin
                rd_ff <= rd_ff + 5'h01;
            end
        end
    end

    // An empty FIFO shows no stale data to the block.
    always_comb begin
        tx_byte_valid = (wr_ff != rd_ff);
        tx_byte       = tx_byte_valid ? mem_ff[rd_ff[3:0]] : ~mem_ff[rd_ff[3:0] - 4'h1];
    end
endmodule : rf_fifo_model

// File: bench/tb_rf_stream_modes.sv
// Self-checking testbench for the RF stream and transparent mode block.
`timescale 1ns/10ps

module tb_rf_stream_modes import rf_stream_pkg::*;;
    logic        clk, sys_rst, clk_en, fc_tick, spi_ss_n, mosi, sclk, cmd_transparent, cmd_any;
    logic        cmd_transmit, spi_miso_data, spi_miso_drive, irq_normal, am_sub, pm_sub;
    logic        field_detect_enable, ext_field, trim_manual, stream_en, rx_enable, push;
    logic        rx_on_normal, sc_detect, sc_phase, ook_sel, tx_byte_valid, tx_byte_ready;
    logic        tx_done, mod_on, mod_ook, rx_on, miso_o, miso_oe, irq_o, transparent;
    logic        low_power_target, rx_start, rx_end, rx_byte_valid;
    logic [3:0]  op_ctrl, trim_value, trim_auto, tuning_switch_pins;
    logic [7:0]  tx_byte, push_byte, rx_byte;
    logic [15:0] txw;
    rx_chan_t    rx_chan;
    stream_cfg_t cfg;
    logic [7:0]  exp_q [$];
    int          n_mismatch;
    int          total_checks;
    int          n;

    rf_stream_modes i_dut (.clk, .sys_rst, .clk_en, .fc_tick, .spi_ss_n, .mosi, .sclk,
        .cmd_transparent, .cmd_any, .cmd_transmit, .spi_miso_data, .spi_miso_drive,
        .irq_normal, .am_sub, .pm_sub, .rx_chan, .field_detect_enable, .ext_field, .op_ctrl,
        .trim_manual, .trim_value, .trim_auto, .stream_en, .cfg, .rx_enable, .rx_on_normal,
        .sc_detect, .sc_phase, .ook_sel, .tx_byte, .tx_byte_valid, .tx_byte_ready, .tx_done,
        .mod_on, .mod_ook, .rx_on, .miso_o, .miso_oe, .irq_o, .transparent, .low_power_target,
        .tuning_switch_pins, .rx_start, .rx_end, .rx_byte, .rx_byte_valid);
    rf_fifo_model i_fifo (.clk, .sys_rst, .push, .push_byte, .tx_byte_ready, .tx_byte,
        .tx_byte_valid);

    always #2 clk = ~clk;

    // ------------------------------------------------------------------
    // Shared checks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_of_test();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic wait_for(ref logic sig, input int lim, output int cnt);
        cnt = 0;
        while (sig !== 1'b1 && cnt < lim) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= lim) begin
            chk("timeout", 8'h00, 8'h01);
            end_of_test();
        end
    endtask : wait_for

    // Received bytes are compared in arrival order against the driver's notes.
    always @(negedge clk) begin
        if (rx_byte_valid === 1'b1) begin
            chk("rx_byte", exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, rx_byte);
        end
        if (transparent === 1'b1 && rx_start !== 1'b0) begin
            chk("rx_start", 8'h00, 8'(rx_start));
        end
    end

    // Phase or presence changes a few cycles into each period to tolerate alignment slop.
    task automatic rx_case(input logic bp, input logic [1:0] f, input logic [1:0] p, int len);
        logic [6:0] pat;
        pat = 7'($urandom);
        // Ending on sub-carrier makes the quiet run nine periods, so 17 bits are written.
        pat[6] = pat[6] | ~bp;
        @(posedge clk);
        cfg <= '{bpsk: bp, scf: f, scp: p, stx: 3'h0};
        rx_enable <= 1'b1;
        sc_detect <= 1'b1;
        sc_phase <= 1'b0;
        exp_q.push_back({pat, ~bp});
        if (!bp) exp_q.push_back(8'h00);
        repeat (len - 2) @(posedge clk);
        sc_detect <= bp;
        repeat (2) @(posedge clk);
        wait_for(rx_start, 4 * len, n);
        for (int i = 0; i < 7; i++) begin
            repeat (2) @(posedge clk);
            sc_detect <= bp | pat[i];
            sc_phase <= pat[i];
            repeat (len - 4) @(posedge clk);
            sc_detect <= bp;
            repeat (2) @(posedge clk);
        end
        sc_detect <= 1'b0;
        wait_for(rx_end, bp ? 2 * len + 4 : 10 * len + 4, n);
        chk("quiet span", 8'h01, 8'(bp || n > 8 * len));
        @(posedge clk);
        rx_enable <= 1'b0;
        chk("pending bytes", 8'h00, 8'(exp_q.size()));
    endtask : rx_case

    initial begin
        {clk, mosi, sclk, cmd_transparent, cmd_any, cmd_transmit, spi_miso_data, am_sub} = '0;
        {pm_sub, field_detect_enable, ext_field, trim_manual, stream_en, rx_enable} = '0;
        {sc_detect, sc_phase, ook_sel, push, op_ctrl, trim_value, trim_auto, push_byte} = '0;
        {spi_miso_drive, irq_normal, rx_on_normal, rx_chan, cfg} = '0;
        {sys_rst, clk_en, fc_tick, spi_ss_n} = 4'hF;
        void'($urandom(32'hFF7F765D));
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {trim_manual, trim_value, trim_auto} <= 9'($urandom);
            repeat (2) @(negedge clk);
            chk("trim", 8'(trim_manual ? trim_value : trim_auto), 8'(tuning_switch_pins));
        end
        @(posedge clk);
        field_detect_enable <= 1'b1;
        repeat (2) @(negedge clk);
        chk("low power", 8'h01, 8'(low_power_target));
        @(posedge clk);
        {clk_en, op_ctrl} <= {1'b0, 4'(1 + $urandom % 15)};
        repeat (2) @(negedge clk);
        chk("frozen", 8'h01, 8'(low_power_target));
        @(posedge clk);
        clk_en <= 1'b1;
        repeat (2) @(negedge clk);
        chk("low power", 8'h00, 8'(low_power_target));
        // ------------------------------------------------------------------
        // Transparent mode
        // ------------------------------------------------------------------
        @(posedge clk);
        {spi_ss_n, cmd_transparent, cmd_any, stream_en, rx_enable, sc_detect} <= 6'h1F;
        cfg <= 8'h68;
        @(posedge clk);
        {cmd_transparent, cmd_any} <= 2'h0;
        @(posedge clk);
        spi_ss_n <= 1'b1;
        repeat (3) @(negedge clk);
        chk("transparent", 8'h01, 8'(transparent));
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            {mosi, sclk, am_sub, pm_sub, ext_field, field_detect_enable, irq_normal} <= 7'($urandom);
            rx_chan <= 2'(1 + $urandom % 3);
            repeat (3) @(negedge clk);
            chk("mod_on", 8'(mosi), 8'(mod_on));
            chk("rx_on", 8'(sclk), 8'(rx_on));
            chk("miso", {7'h01, rx_chan.am_en ? am_sub : pm_sub}, {7'(miso_oe), miso_o});
            chk("irq", 8'(field_detect_enable ? ext_field : &rx_chan & pm_sub), 8'(irq_o));
            chk("rx_start", 8'h00, 8'(rx_start));
        end
        @(posedge clk);
        {cmd_any, rx_enable, sc_detect} <= 3'h4;
        @(posedge clk);
        cmd_any <= 1'b0;
        repeat (2) @(negedge clk);
        chk("transparent", 8'h00, 8'(transparent));
        @(posedge clk);
        spi_ss_n <= 1'b0;
        @(posedge clk);
        spi_ss_n <= 1'b1;
        repeat (3) @(negedge clk);
        chk("transparent", 8'h00, 8'(transparent));
        // ------------------------------------------------------------------
        // Stream transmission and reception
        // ------------------------------------------------------------------
        txw = 16'($urandom);
        @(posedge clk);
        {ook_sel, push, push_byte} <= {1'($urandom), 1'b1, txw[7:0]};
        @(posedge clk);
        push_byte <= txw[15:8];
        @(posedge clk);
        push <= 1'b0;
        repeat (20) @(negedge clk);
        chk("idle tx", 8'h00, {6'h00, mod_on, tx_byte_ready});
        @(posedge clk);
        cmd_transmit <= 1'b1;
        @(posedge clk);
        cmd_transmit <= 1'b0;
        repeat (66) @(posedge clk);
        for (int k = 0; k < 16; k++) begin
            if (k == 8) @(posedge clk);
            @(negedge clk);
            chk("mod_on", {7'h00, txw[k]}, {mod_ook ^ ook_sel, 6'h00, mod_on});
            repeat (k == 15 ? 0 : 127) @(posedge clk);
        end
        wait_for(tx_done, 200, n);
        rx_case(1'b0, 2'h1, 2'h2, 128);
        rx_case(1'b0, 2'h3, 2'h1, 16);
        rx_case(1'b0, 2'h0, 2'h3, 512);
        rx_case(1'b1, 2'h1, 2'h1, 16);
        rx_case(1'b1, 2'h2, 2'h3, 32);
        rx_case(1'b1, 2'h0, 2'h0, 16);
        end_of_test();
    end
endmodule : tb_rf_stream_modes
